// [hdl/rtc_params.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// ============================================================
// Register offsets
`define RTC_OFS_REDUND    8'h22
`define RTC_OFS_SEED_LO   8'h23
`define RTC_OFS_SEED_HI   8'h24
`define RTC_OFS_SLOT      8'h25
`define RTC_OFS_AUX       8'h26
`define RTC_OFS_PRESET    8'h27
`define RTC_OFS_THR       8'h29
`define RTC_OFS_IRQ_STAT  8'h30
`define RTC_OFS_IRQ_MASK  8'h31
// ============================================================
// Reset values
`define RTC_RST_REDUND    8'h03
`define RTC_RST_SEED      8'h63
`define RTC_RST_ZERO      8'h00
`define RTC_RST_THR       8'h08
// ============================================================
// Field positions and codes
`define RTC_BIT_SHORT     4
`define RTC_BIT_RXCRC     3
`define RTC_BIT_TXCRC     2
`define RTC_BIT_SLOT_TOP  4
`define RTC_AUX_LOW       3'h0
`define RTC_AUX_HIGH      3'h1
`define RTC_AUX_ENV       3'h2
`define RTC_AUX_DATA      3'h3
`define RTC_AUX_CARRIER   3'h4
`define RTC_AUX_SUBCAR    3'h5
`define RTC_FIFO_DEPTH    7'h40
`define RTC_IRQ_FULL      0
`define RTC_IRQ_EMPTY     1
`define RTC_IRQ_SLOT      2
// ============================================================
// Timing
`define RTC_CLK_PERIOD_NS 8
`define RTC_SLOT_UNIT_NS  1000
`endif

// [hdl/rtc_pkg.sv]
// Types shared by the configuration register block
`default_nettype none
package rtc_pkg;
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rtc_req_s;
	// Framer events, one-cycle pulses
	typedef struct packed {
		logic tx_start;
		logic rx_start;
		logic calc_start;
		logic cmd_end;
		logic slot_stop;
	} rtc_ev_s;
	// Internal signals for the auxiliary pin; base_rate_type_a only qualifies the demodulator taps
	typedef struct packed {
		logic miller_env;
		logic serial_data;
		logic carrier_demod;
		logic subcarrier_demod;
		logic base_rate_type_a;
	} rtc_src_s;
	typedef enum logic {RTC_IDLE, RTC_COUNT} rtc_slot_e;
	// Whole state of the block
	typedef struct packed {
		logic [7:0] redund;
		logic [7:0] seed_lo;
		logic [7:0] seed_hi;
		logic [7:0] slot_lo;
		logic [7:0] aux_sel;
		logic [7:0] preset;
		logic [7:0] thr;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic [7:0] rdata;
		logic       seed_load;
		logic [15:0] seed_value;
		logic       crc_short;
		logic       aux_pin;
		logic       demod_valid;
		logic       near_full;
		logic       near_empty;
		logic       auto_frame;
		logic       irq;
		rtc_slot_e  slot_state;
		logic [8:0] slot_cnt;
		logic [6:0] div_cnt;
	} rtc_state_s;
endpackage
`default_nettype wire

// [hdl/rtc_config_regs.sv]
// Checksum seed, slot interval, auxiliary pin and FIFO alert registers
`default_nettype none
`include "rtc_params.svh"
module rtc_config_regs
	import rtc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Register port
	input  wire rtc_req_s   req,
	output logic [7:0]      rdata,
	// Framer and FIFO status
	input  wire rtc_ev_s    ev,
	input  wire rtc_src_s   src,
	input  wire logic [6:0] fifo_level,
	// Checksum generator
	output logic            seed_load,
	output logic [15:0]     seed_value,
	output logic            crc_short,
	// Slot timing
	output logic [8:0]      slot_interval,
	output logic            auto_frame,
	// Auxiliary pin and preset slot
	output logic            aux_test_output_pin,
	output logic            aux_demod_valid,
	output logic [7:0]      preset_slot_27,
	// FIFO alerts and interrupt
	output logic            fifo_nearly_full_flag,
	output logic            fifo_nearly_empty_flag,
	output logic            irq
);

	// ============================================================
	// Constants
	// Slot unit rounded up to whole clocks
	localparam int         SLOT_CYC  = (`RTC_SLOT_UNIT_NS
		+ `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS;
	localparam logic [6:0] SLOT_LAST = 7'(SLOT_CYC - 1);

	rtc_state_s st;
	rtc_state_s next_st;
	logic [8:0] interval;
	logic [6:0] free_space;
	logic [5:0] alert_thr;
	logic       slot_tick;
	logic [2:0] irq_events;

	// ============================================================
	// Functions
	// Pin source decode; reserved codes fall to low
	function automatic logic aux_mux(input logic [2:0] sel,
		input rtc_src_s s);
		logic v;
		v = 1'b0;
		case (sel)
			`RTC_AUX_LOW:     v = 1'b0;
			`RTC_AUX_HIGH:    v = 1'b1;
			`RTC_AUX_ENV:     v = s.miller_env;
			`RTC_AUX_DATA:    v = s.serial_data;
			`RTC_AUX_CARRIER: v = s.carrier_demod;
			`RTC_AUX_SUBCAR:  v = s.subcarrier_demod;
			default:          v = 1'b0;
		endcase
		return v;
	endfunction

	// Selection of a demodulator tap, used once for the validity tag
	function automatic logic is_demod(input logic [2:0] sel);
		return (sel == `RTC_AUX_CARRIER) || (sel == `RTC_AUX_SUBCAR);
	endfunction

	// Read decode; write-only and unmapped offsets read zero
	function automatic logic [7:0] read_mux(input logic [7:0] a,
		input rtc_state_s s);
		logic [7:0] d;
		d = 8'h00;
		if (a == `RTC_OFS_REDUND) begin
			d = s.redund;
		end else if (a == `RTC_OFS_SEED_LO) begin
			d = s.seed_lo;
		end else if (a == `RTC_OFS_SEED_HI) begin
			d = s.seed_hi;
		end else if (a == `RTC_OFS_SLOT) begin
			d = s.slot_lo;
		end else if (a == `RTC_OFS_AUX) begin
			d = s.aux_sel;
		end else if (a == `RTC_OFS_THR) begin
			d = s.thr;
		end else if (a == `RTC_OFS_IRQ_STAT) begin
			d = {5'h00, s.irq_stat};
		end else if (a == `RTC_OFS_IRQ_MASK) begin
			d = {5'h00, s.irq_mask};
		end else begin
			d = 8'h00;
		end
		return d;
	endfunction

	// ============================================================
	// Derived terms
	// Nine-bit interval joined from two registers
	assign interval   = {st.aux_sel[`RTC_BIT_SLOT_TOP], st.slot_lo};
	assign free_space = 7'(`RTC_FIFO_DEPTH - fifo_level);
	assign alert_thr  = st.thr[5:0];
	assign slot_tick  = (st.div_cnt == SLOT_LAST);

	// ============================================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.seed_load  = 1'b0;
		next_st.auto_frame = 1'b0;
		next_st.rdata      = 8'h00;

		// Register writes; fixed-zero bits are stored as written
		if (req.wr) begin
			if (req.addr == `RTC_OFS_REDUND) begin
				next_st.redund = req.wdata;
			end else if (req.addr == `RTC_OFS_SEED_LO) begin
				next_st.seed_lo = req.wdata;
			end else if (req.addr == `RTC_OFS_SEED_HI) begin
				next_st.seed_hi = req.wdata;
			end else if (req.addr == `RTC_OFS_SLOT) begin
				next_st.slot_lo = req.wdata;
			end else if (req.addr == `RTC_OFS_AUX) begin
				next_st.aux_sel = req.wdata;
			end else if (req.addr == `RTC_OFS_PRESET) begin
				next_st.preset = req.wdata;
			end else if (req.addr == `RTC_OFS_THR) begin
				next_st.thr = req.wdata;
			end else if (req.addr == `RTC_OFS_IRQ_MASK) begin
				next_st.irq_mask = req.wdata[2:0];
			end
		end

		// Read data stands only in the cycle after the strobe
		if (req.rd) begin
			next_st.rdata = read_mux(req.addr, st);
		end

		// Seed load; short mode blanks the upper byte
		if ((ev.tx_start && st.redund[`RTC_BIT_TXCRC]) ||
			(ev.rx_start && st.redund[`RTC_BIT_RXCRC]) ||
			ev.calc_start) begin
			next_st.seed_load = 1'b1;
			next_st.crc_short = st.redund[`RTC_BIT_SHORT];
			next_st.seed_value[7:0] = st.seed_lo;
			if (st.redund[`RTC_BIT_SHORT]) begin
				next_st.seed_value[15:8] = 8'h00;
			end else begin
				next_st.seed_value[15:8] = st.seed_hi;
			end
		end

		// Slot timer, started by the end of the command frame.
		// The host offsets the interval to the frame start itself.
		case (st.slot_state)
			RTC_IDLE: begin
				next_st.div_cnt = 7'h00;
				if (ev.cmd_end && interval != 9'h000) begin
					next_st.slot_state = RTC_COUNT;
					next_st.slot_cnt   = interval;
				end
			end
			RTC_COUNT: begin
				next_st.div_cnt = slot_tick ? 7'h00 : st.div_cnt + 7'h01;
				if (ev.slot_stop || interval == 9'h000) begin
					next_st.slot_state = RTC_IDLE;
				end else if (ev.cmd_end) begin
					next_st.slot_cnt = interval;
					next_st.div_cnt  = 7'h00;
				end else if (slot_tick) begin
					if (st.slot_cnt <= 9'h001) begin
						// Repeat spacing for the next frame
						next_st.auto_frame = 1'b1;
						next_st.slot_cnt   = interval;
					end else begin
						next_st.slot_cnt = st.slot_cnt - 9'h001;
					end
				end
			end
			default: begin
				next_st.slot_state = RTC_IDLE;
			end
		endcase

		// Pin source; demodulator taps are flagged as meaningful
		// only during type A traffic at the base rate
		next_st.aux_pin     = aux_mux(st.aux_sel[2:0], src);
		next_st.demod_valid = is_demod(st.aux_sel[2:0])
			& src.base_rate_type_a;

		// FIFO alert comparisons against the six-bit threshold
		next_st.near_full  = free_space <= {1'b0, alert_thr};
		next_st.near_empty = fifo_level <= {1'b0, alert_thr};

		// Rising alerts and each automatic frame are interrupt events.
		// Kept inside this process so no loop runs through next_st.
		irq_events = {
			next_st.auto_frame,
			next_st.near_empty & ~st.near_empty,
			next_st.near_full & ~st.near_full
		};

		// Sticky status: an event in the clearing cycle survives
		for (int i = 0; i < 3; i++) begin
			if (irq_events[i]) begin
				next_st.irq_stat[i] = 1'b1;
			end else if (req.wr && req.addr == `RTC_OFS_IRQ_STAT &&
				req.wdata[i]) begin
				next_st.irq_stat[i] = 1'b0;
			end
		end
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
	end

	// ============================================================
	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st            <= '0;
			st.redund     <= `RTC_RST_REDUND;
			st.seed_lo    <= `RTC_RST_SEED;
			st.seed_hi    <= `RTC_RST_SEED;
			st.slot_lo    <= `RTC_RST_ZERO;
			st.aux_sel    <= `RTC_RST_ZERO;
			st.preset     <= `RTC_RST_ZERO;
			st.thr        <= `RTC_RST_THR;
			st.slot_state <= RTC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ============================================================
	// Outputs, all straight from the state register
	assign rdata                  = st.rdata;
	assign seed_load              = st.seed_load;
	assign seed_value             = st.seed_value;
	assign crc_short              = st.crc_short;
	assign slot_interval          = interval;
	assign auto_frame             = st.auto_frame;
	assign aux_test_output_pin    = st.aux_pin;
	assign aux_demod_valid        = st.demod_valid;
	assign preset_slot_27         = st.preset;
	assign fifo_nearly_full_flag  = st.near_full;
	assign fifo_nearly_empty_flag = st.near_empty;
	assign irq                    = st.irq;

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Upper seed byte takes any written value
	seed_write_a: assert property (
		req.wr && req.addr == `RTC_OFS_SEED_HI
		|=> st.seed_hi == $past(req.wdata))
		else $error("upper seed byte not written");

	// A transmit start with checksum on loads the seed
	seed_load_a: assert property (
		ev.tx_start && st.redund[`RTC_BIT_TXCRC]
		&& !st.redund[`RTC_BIT_SHORT]
		|=> seed_load && seed_value[15:8] == $past(st.seed_hi))
		else $error("seed not loaded at transmit start");

	// Short mode never passes the upper byte
	short_seed_a: assert property (
		seed_load && crc_short |-> seed_value[15:8] == 8'h00)
		else $error("upper seed byte used in short mode");

	// Width select follows the register bit
	width_sel_a: assert property (
		$rose(seed_load) |-> crc_short
			== $past(st.redund[`RTC_BIT_SHORT]))
		else $error("checksum width not taken from register");

	// Lower half of the seed
	seed_low_a: assert property (
		seed_load |-> seed_value[7:0] == $past(st.seed_lo))
		else $error("lower seed byte wrong");

	// Interval count starts at the command end
	slot_start_a: assert property (
		st.slot_state == RTC_IDLE && ev.cmd_end && interval != 9'h000
		|=> st.slot_state == RTC_COUNT && st.slot_cnt == $past(interval))
		else $error("slot count not started at command end");

	// Top interval bit comes from bit 4 of the source register
	slot_top_a: assert property (
		req.wr && req.addr == `RTC_OFS_AUX
		|=> slot_interval[8] == $past(req.wdata[`RTC_BIT_SLOT_TOP]))
		else $error("interval top bit not from source register");

	// Constant high source, held for two cycles
	aux_const_a: assert property (
		st.aux_sel[2:0] == `RTC_AUX_HIGH ##1
		st.aux_sel[2:0] == `RTC_AUX_HIGH |-> aux_test_output_pin)
		else $error("constant high source not on pin");

	// Reserved codes drive the pin low
	aux_reserved_a: assert property (
		st.aux_sel[2:1] == 2'b11 |=> !aux_test_output_pin)
		else $error("reserved source code not low");

	// Subcarrier tap follows its source one cycle later
	aux_subcar_a: assert property (
		st.aux_sel[2:0] == `RTC_AUX_SUBCAR && !req.wr
		|=> aux_test_output_pin == $past(src.subcarrier_demod))
		else $error("subcarrier tap not routed");

	// Validity tag needs base rate traffic
	demod_valid_a: assert property (
		aux_demod_valid |-> $past(src.base_rate_type_a))
		else $error("demodulator tap tagged valid off base rate");

	// Alert flags track the comparisons
	// Free space within threshold is fill plus threshold reaching depth
	full_flag_a: assert property (
		##1 fifo_nearly_full_flag == (8'($past(fifo_level))
			+ 8'($past(st.thr[5:0])) >= 8'h40))
		else $error("nearly-full flag wrong");
	empty_flag_a: assert property (
		##1 fifo_nearly_empty_flag
			== ($past(fifo_level) <= {1'b0, $past(st.thr[5:0])}))
		else $error("nearly-empty flag wrong");

	// Preset slot reads back as zero
	preset_read_a: assert property (
		req.rd && req.addr == `RTC_OFS_PRESET |=> rdata == 8'h00)
		else $error("write-only slot readable");

	// Interrupt line follows unmasked status
	irq_level_a: assert property (
		|(st.irq_stat & st.irq_mask) |-> irq)
		else $error("interrupt not raised");

	// Each automatic frame leaves its status bit set, even if cleared
	frame_status_a: assert property (
		auto_frame |-> st.irq_stat[`RTC_IRQ_SLOT])
		else $error("frame event lost in status");

	// Read data falls back to zero once its cycle is over
	rdata_idle_a: assert property (
		!req.rd |=> rdata == 8'h00)
		else $error("read data stands too long");

	// Refused transmit start leaves the generator alone
	tx_refused_a: assert property (
		ev.tx_start && !st.redund[`RTC_BIT_TXCRC] && !ev.rx_start
		&& !ev.calc_start |=> !seed_load)
		else $error("seed loaded with transmit checksum off");

	// Receive start with checksum on loads the seed
	rx_load_a: assert property (
		ev.rx_start && st.redund[`RTC_BIT_RXCRC] |=> seed_load)
		else $error("seed not loaded at receive start");

	// A zero interval halts the timer and sends nothing
	slot_zero_a: assert property (
		interval == 9'h000 |=> st.slot_state == RTC_IDLE && !auto_frame)
		else $error("timer runs with zero interval");

	// Constant low source, held for two cycles
	aux_low_a: assert property (
		st.aux_sel[2:0] == `RTC_AUX_LOW ##1
		st.aux_sel[2:0] == `RTC_AUX_LOW |-> !aux_test_output_pin)
		else $error("constant low source not on pin");

	// Preset slot takes any written value
	preset_write_a: assert property (
		req.wr && req.addr == `RTC_OFS_PRESET
		|=> preset_slot_27 == $past(req.wdata))
		else $error("write-only slot not written");

	// Source register keeps reserved bits as written
	aux_keep_a: assert property (
		req.wr && req.addr == `RTC_OFS_AUX
		|=> st.aux_sel == $past(req.wdata))
		else $error("source register not kept as written");

	// Main scenarios
	auto_frame_c: cover property (st.slot_state == RTC_COUNT
		##1 auto_frame);
	short_load_c: cover property (seed_load && crc_short);
	long_load_c:  cover property (seed_load && !crc_short);
	irq_raise_c:  cover property ($rose(irq));
	demod_tap_c:  cover property (aux_demod_valid);

endmodule
`default_nettype wire

// [bench/rtc_host_model.sv]
// Host processor model that drives the register port of the block
`default_nettype none
module rtc_host_model
	import rtc_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Register port
	output var  rtc_req_s   req,
	input  wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Bus idle state
	initial req = '0;

	// Released lines show the inverse so stale values never pass
	task automatic idle();
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		req.addr <= ~req.addr;
		req.wdata <= ~req.wdata;
		#1;
	endtask

	// ============================================================
	// One-cycle write; fixed-zero bits of offsets 22, 26 and 29 are sent as zero, other offsets as given
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = (a == 8'h26) ? 8'h17 : 8'hFF;
		m = (a == 8'h29 || a == 8'h22) ? 8'h3F : m;
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d & m;
		req.wr <= 1'b1;
		@(posedge clk);
		idle();
	endtask

	// One-cycle read; data stands only in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		idle();
		d = rdata;
	endtask
endmodule
`default_nettype wire

// [bench/test_rtc_config_regs.sv]
// Self-checking bench for the configuration register block
`default_nettype none
module test_rtc_config_regs
	import rtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Signals
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	rtc_req_s    req;
	logic [7:0]  rdata;
	rtc_ev_s     ev = '0;
	rtc_src_s    src = '0;
	logic [6:0]  fifo_level = 7'h14;
	logic        seed_load;
	logic [15:0] seed_value;
	logic        crc_short;
	logic [8:0]  slot_interval;
	logic        auto_frame;
	logic        aux_test_output_pin;
	logic        aux_demod_valid;
	logic [7:0]  preset_slot_27;
	logic        fifo_nearly_full_flag;
	logic        fifo_nearly_empty_flag;
	logic        irq;
	int          miscompares = 0;
	int          checked = 0;
	logic [7:0]  v;
	int          n;
	logic [3:0]  pt;
	logic [7:0]  ofs [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
		8'h27, 8'h28, 8'h29, 8'h30, 8'h31};
	logic [7:0]  rst [10] = '{8'h03, 8'h63, 8'h63, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
	logic [6:0]  lvl [6] = '{7'd8, 7'd9, 7'd56, 7'd55, 7'd64, 7'd0};
	logic [5:0]  full_x = 6'b001010;
	logic [5:0]  empty_x = 6'b100001;
	logic [3:0]  pats [4] = '{4'hA, 4'hC, 4'h5, 4'h3};

	// Free-running 125 MHz clock
	always #4 clk = ~clk;

	// ============================================================
	// Design and host model
	rtc_config_regs i_rtc_config_regs (
		.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .ev(ev),
		.src(src), .fifo_level(fifo_level), .seed_load(seed_load),
		.seed_value(seed_value), .crc_short(crc_short),
		.slot_interval(slot_interval), .auto_frame(auto_frame),
		.aux_test_output_pin(aux_test_output_pin),
		.aux_demod_valid(aux_demod_valid),
		.preset_slot_27(preset_slot_27),
		.fifo_nearly_full_flag(fifo_nearly_full_flag),
		.fifo_nearly_empty_flag(fifo_nearly_empty_flag), .irq(irq));
	rtc_host_model i_rtc_host_model (
		.clk(clk), .req(req), .rdata(rdata));

	// ============================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("counts: %0d checked, %0d miscompares", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One-cycle framer pulse; returns once the taking edge has landed
	task automatic pulse(input logic [4:0] e);
		@(posedge clk);
		ev <= rtc_ev_s'(e);
		@(posedge clk);
		ev <= '0;
		#1;
	endtask

	// Cycles until the next automatic frame, bounded against a hang
	task automatic wait_frame(input int lim, output int c);
		c = 0;
		while (auto_frame !== 1'b1 && c < lim) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask

	// Expected pin level for a source code and a set of source levels
	function automatic logic aux_exp(input logic [2:0] c, input logic [3:0] p);
		case (c)
			3'h1: return 1'b1;
			3'h2: return p[3];
			3'h3: return p[2];
			3'h4: return p[1];
			3'h5: return p[0];
			default: return 1'b0;
		endcase
	endfunction

	// ============================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Reset contents, an unmapped place and the write-only slot
		foreach (ofs[i]) begin
			i_rtc_host_model.rd(ofs[i], v);
			check(v, rst[i]);
		end
		check(aux_test_output_pin, 1'b0);
		$display("test reset values done");

		// Alert flags at the default threshold, boundaries both sides
		foreach (lvl[i]) begin
			@(posedge clk);
			fifo_level <= lvl[i];
			repeat (2) @(posedge clk);
			#1;
			check(fifo_nearly_full_flag, full_x[5-i]);
			check(fifo_nearly_empty_flag, empty_x[5-i]);
		end
		i_rtc_host_model.rd(8'h30, v);
		check(v, 8'h03);
		check(irq, 1'b0);
		i_rtc_host_model.wr(8'h31, 8'h03);
		@(posedge clk);
		#1;
		check(irq, 1'b1);
		i_rtc_host_model.wr(8'h30, 8'h03);
		@(posedge clk);
		#1;
		check(irq, 1'b0);
		i_rtc_host_model.rd(8'h30, v);
		check(v, 8'h00);
		$display("test fifo alerts done");

		// Every source code against four patterns of source levels
		for (int c = 0; c < 8; c++) begin
			i_rtc_host_model.wr(8'h26, {5'h00, 3'(c)});
			foreach (pats[j]) begin
				pt = pats[j];
				@(posedge clk);
				src <= {pt, 1'b1};
				repeat (2) @(posedge clk);
				#1;
				check(aux_test_output_pin, aux_exp(3'(c), pt));
				check(aux_demod_valid, c == 4 || c == 5);
			end
		end
		i_rtc_host_model.wr(8'h26, 8'h05);
		@(posedge clk);
		src <= {4'hF, 1'b0};
		repeat (2) @(posedge clk);
		#1;
		check(aux_demod_valid, 1'b0);
		$display("test aux pin done");

		// Seed loads: refused while disabled, short mode, both halves
		i_rtc_host_model.wr(8'h24, 8'hA5);
		pulse(5'h10);
		check(seed_load, 1'b0);
		pulse(5'h04);
		check({seed_load, crc_short}, 2'b10);
		check(seed_value, 16'hA563);
		i_rtc_host_model.wr(8'h22, 8'h1C);
		pulse(5'h10);
		check({seed_load, crc_short}, 2'b11);
		check(seed_value, 16'h0063);
		pulse(5'h08);
		check(seed_load, 1'b1);
		i_rtc_host_model.wr(8'h22, 8'h0C);
		pulse(5'h10);
		check({seed_load, crc_short}, 2'b10);
		check(seed_value, 16'hA563);
		$display("test seed load done");

		// Slot timer of one unit, repeated frames, stop, zero interval
		i_rtc_host_model.wr(8'h25, 8'h01);
		i_rtc_host_model.wr(8'h26, 8'h00);
		i_rtc_host_model.wr(8'h31, 8'h04);
		pulse(5'h02);
		wait_frame(300, n);
		check(n >= 125 && n <= 126, 1'b1);
		if (n >= 300)
			report_and_stop();
		@(posedge clk);
		#1;
		check(irq, 1'b1);
		wait_frame(300, n);
		check(n, 16'd124);
		if (n >= 300)
			report_and_stop();
		pulse(5'h01);
		i_rtc_host_model.wr(8'h25, 8'h00);
		i_rtc_host_model.wr(8'h30, 8'h07);
		i_rtc_host_model.rd(8'h30, v);
		check(v, 8'h00);
		check(irq, 1'b0);
		pulse(5'h02);
		wait_frame(300, n);
		check(n, 16'd300);
		$display("test slot timer done");

		// Read-back, nine-bit interval, write-only slot
		i_rtc_host_model.wr(8'h25, 8'hC3);
		i_rtc_host_model.wr(8'h26, 8'h16);
		i_rtc_host_model.wr(8'h27, 8'h5A);
		i_rtc_host_model.rd(8'h24, v);
		check(v, 8'hA5);
		i_rtc_host_model.rd(8'h26, v);
		check(v, 8'h16);
		check(slot_interval, 9'h1C3);
		check(aux_test_output_pin, 1'b0);
		check(preset_slot_27, 8'h5A);
		i_rtc_host_model.rd(8'h27, v);
		check(v, 8'h00);
		$display("test read back done");
		report_and_stop();
	end
endmodule
`default_nettype wire
